// File: design/cco_options.sv
// Converter options register, integrity checks and output formatting.
// Function
// - Options register at index 8h resets to 00h.
// - Bit 7 picks conversion clock: 0 internal, 1 external.
// - Bit 6 divides external clock by eight when set.
// - Bit 5 holds drive strength: 0 full, 1 half.
// - Bit 3 picks result width: 0 gives 24 bits, 1 gives 16.
// - Failed incoming frame CRC sets link error flag when enabled.
// - Link error flag stays set until host writes one to it.
// - With bit 1 set, map CRC mismatch sets the map error flag.
// - Bit 0 prepends status byte to each conversion output.
// - Map CRC polynomial is x^8+x^2+x+1.
// - Map CRC starts from all ones.
// - Map comparison repeats continuously while enabled.
`timescale 1ns/1ps
module cco_options
   import cco_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [3:0]  i_pstrb,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_ext_clk,
   input  wire logic        i_frame_done,
   input  wire logic        i_frame_crc_bad,
   input  wire logic        i_conv_valid,
   input  wire logic [23:0] i_conv_data,
   output logic             o_conv_ready,
   output logic             o_out_valid,
   input  wire logic        i_out_ready,
   output logic [7:0]       o_out_status,
   output logic             o_out_status_en,
   output logic [23:0]      o_out_data,
   output logic             o_out_res16,
   output logic [7:0]       o_out_crc,
   output logic             o_out_crc_en,
   output logic             o_clk_tick,
   output logic             o_clk_ext_sel,
   output logic             o_output_drive_half,
   output logic             o_link_err,
   output logic             o_map_err
);

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   logic [7:0]  options_q;
   logic [7:0]  map_crc_q;
   logic [7:0]  map_regs_q [MAP_REGS];
   logic        link_err_q;
   logic        map_err_q;
   logic        ext_prev_q;
   logic [2:0]  div_q;
   logic        wr_en;
   logic        hit_map;
   logic [3:0]  map_idx;
   logic        mapped;
   logic [7:0]  status_byte;

   assign wr_en   = i_psel & i_penable & i_pwrite & o_pready;
   assign hit_map = (i_paddr >= ADDR_MAP_BASE) && (i_paddr <= ADDR_MAP_LAST)
                    && (i_paddr[1:0] == 2'b00);
   assign map_idx = 4'((i_paddr - ADDR_MAP_BASE) >> 2);
   assign mapped  = hit_map || (i_paddr == ADDR_OPTIONS)
                    || (i_paddr == ADDR_MAP_CRC) || (i_paddr == ADDR_STATUS);
   assign status_byte = {6'h00, link_err_q, map_err_q};

   // Single-cycle access phase keeps the bench free of wait states.
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end
      else
      begin
         o_pready  <= i_psel & ~i_penable;
         o_pslverr <= i_psel & ~i_penable & ~mapped;
         if (i_psel & ~i_penable & ~i_pwrite)
         begin
            if (i_paddr == ADDR_OPTIONS)
               o_prdata <= {24'h000000, options_q};
            else if (i_paddr == ADDR_MAP_CRC)
               o_prdata <= {24'h000000, map_crc_q};
            else if (i_paddr == ADDR_STATUS)
               o_prdata <= {24'h000000, status_byte};
            else if (hit_map)
               o_prdata <= {24'h000000, map_regs_q[map_idx]};
            else
               o_prdata <= 32'h0000_0000;
         end
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         options_q <= OPTIONS_RESET;
         map_crc_q <= 8'h00;
      end
      else if (wr_en && i_pstrb[0])
      begin
         if (i_paddr == ADDR_OPTIONS)
            options_q <= i_pwdata[7:0] & OPTIONS_WMASK;
         if (i_paddr == ADDR_MAP_CRC)
            map_crc_q <= i_pwdata[7:0];
      end
   end

   // Covered map bytes stand in for the registers outside this block.
   for (genvar g = 0; g < MAP_REGS; g++)
   begin : g_map
      always_ff @(posedge i_ref_clk or negedge i_rst_n)
      begin
         if (!i_rst_n)
            map_regs_q[g] <= 8'h00;
         else if (wr_en && i_pstrb[0] && hit_map && map_idx == 4'(g))
            map_regs_q[g] <= i_pwdata[7:0];
      end
   end

   // ------------------------------------------------------------------
   // Link CRC error flag
   // ------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         link_err_q <= 1'b0;
      else if (options_q[BIT_LINK_CRC] && i_frame_done && i_frame_crc_bad)
         link_err_q <= 1'b1;
      else if (wr_en && i_pstrb[0] && i_paddr == ADDR_STATUS
               && i_pwdata[BIT_LINK_ERR])
         link_err_q <= 1'b0;
   end

   // ------------------------------------------------------------------
   // Continuous register map check
   // ------------------------------------------------------------------
   cco_map_state_t map_st_q;
   logic [3:0]     walk_q;
   logic [7:0]     crc_acc_q;

   // Walk covers all bytes 0..Ch at steps 0,1 and 4..Eh; steps 2 and 3 add nothing.
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         map_st_q  <= MAP_IDLE;
         walk_q    <= 4'h0;
         crc_acc_q <= CRC_PRESET;
      end
      else
      begin
         case (map_st_q)
            MAP_IDLE:
            begin
               walk_q    <= 4'h0;
               crc_acc_q <= CRC_PRESET;
               if (options_q[BIT_MAP_CRC])
                  map_st_q <= MAP_WALK;
            end
            MAP_WALK:
            begin
               if (walk_q == 4'h1 || (walk_q >= 4'h4 && walk_q <= 4'hE))
                  crc_acc_q <= crc8_byte(crc_acc_q,
                     map_regs_q[walk_q - (walk_q >= 4'h4 ? 4'h2 : 4'h0)]);
               else if (walk_q == 4'h0)
                  crc_acc_q <= crc8_byte(crc_acc_q, map_regs_q[0]);
               if (walk_q == 4'hE)
                  map_st_q <= MAP_DONE;
               walk_q <= walk_q + 4'h1;
            end
            MAP_DONE:
               map_st_q <= MAP_IDLE;
            default:
               map_st_q <= MAP_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         map_err_q <= 1'b0;
      else if (map_st_q == MAP_DONE && options_q[BIT_MAP_CRC]
               && crc_acc_q != map_crc_q)
         map_err_q <= 1'b1;
      else if (wr_en && i_pstrb[0] && i_paddr == ADDR_STATUS
               && i_pwdata[BIT_MAP_ERR])
         map_err_q <= 1'b0;
   end

   // ------------------------------------------------------------------
   // Conversion clock selection
   // ------------------------------------------------------------------
   logic ext_rise;
   assign ext_rise = i_ext_clk & ~ext_prev_q;

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ext_prev_q <= 1'b0;
         div_q      <= 3'h0;
         o_clk_tick <= 1'b0;
      end
      else
      begin
         ext_prev_q <= i_ext_clk;
         if (ext_rise)
            div_q <= div_q + 3'h1;
         if (!options_q[BIT_CLK_EXT])
            o_clk_tick <= 1'b1;
         else if (options_q[BIT_CLK_DIV8])
            o_clk_tick <= ext_rise && div_q == EXT_DIV_LAST;
         else
            o_clk_tick <= ext_rise;
      end
   end

   // ------------------------------------------------------------------
   // Output formatting into the FIFO
   // ------------------------------------------------------------------
   cco_word_t in_w;
   cco_word_t out_w;
   logic      fifo_in_ready;
   logic [23:0] shaped;

   assign shaped = options_q[BIT_RES16]
                   ? {8'h00, i_conv_data[23:8]}
                   : i_conv_data;
   assign in_w.status_valid = options_q[BIT_STAT_PRE];
   assign in_w.status       = status_byte;
   assign in_w.data         = shaped;
   assign in_w.res16        = options_q[BIT_RES16];
   assign in_w.crc          = crc8_byte(crc8_byte(crc8_byte(
                                 crc8_byte(CRC_PRESET,
                                 options_q[BIT_STAT_PRE] ? status_byte
                                                         : 8'hFF),
                                 shaped[23:16]), shaped[15:8]), shaped[7:0]);
   assign in_w.crc_valid    = options_q[BIT_LINK_CRC];

   logic out_valid_w;

   cco_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (i_conv_valid),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (in_w),
      .o_out_valid (out_valid_w),
      .i_out_ready (i_out_ready & o_out_valid),
      .o_out_data  (out_w)
   );

   // Registered mirror of the FIFO head; a pop advances it next cycle.
   logic popped_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_out_valid        <= 1'b0;
         o_out_status       <= 8'h00;
         o_out_status_en    <= 1'b0;
         o_out_data         <= 24'h000000;
         o_out_res16        <= 1'b0;
         o_out_crc          <= 8'h00;
         o_out_crc_en       <= 1'b0;
         o_conv_ready       <= 1'b0;
         o_clk_ext_sel      <= 1'b0;
         o_output_drive_half <= 1'b0;
         o_link_err         <= 1'b0;
         o_map_err          <= 1'b0;
         popped_q           <= 1'b0;
      end
      else
      begin
         popped_q        <= i_out_ready & o_out_valid;
         o_out_valid     <= out_valid_w & ~(i_out_ready & o_out_valid)
                            & ~popped_q;
         o_out_status    <= out_w.status;
         o_out_status_en <= out_w.status_valid;
         o_out_data      <= out_w.data;
         o_out_res16     <= out_w.res16;
         o_out_crc       <= out_w.crc;
         o_out_crc_en    <= out_w.crc_valid;
         o_conv_ready    <= fifo_in_ready;
         o_clk_ext_sel   <= options_q[BIT_CLK_EXT];
         o_output_drive_half <= options_q[BIT_DRIVE_HALF];
         o_link_err      <= link_err_q;
         o_map_err       <= map_err_q;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_reserved_zero : assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) options_q[BIT_RESERVED] == 1'b0)
      else $error("Reserved bit set.");
   a_link_err_set : assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) options_q[BIT_LINK_CRC] && i_frame_done
      && i_frame_crc_bad |=> link_err_q)
      else $error("Link error not raised.");
   a_link_err_sticky : assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) link_err_q && !(wr_en
      && i_paddr == ADDR_STATUS) |=> link_err_q)
      else $error("Link error dropped.");
   a_map_err_set : assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) map_st_q == MAP_DONE
      && options_q[BIT_MAP_CRC] && crc_acc_q != map_crc_q |=> map_err_q)
      else $error("Map error not raised.");
   a_map_walk_bound : assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) options_q[BIT_MAP_CRC]
      |-> ##[0:18] map_st_q == MAP_DONE)
      else $error("Map check stalled.");
   a_int_clock_tick : assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) i_rst_n && !options_q[BIT_CLK_EXT] ##1
      !options_q[BIT_CLK_EXT] |-> o_clk_tick)
      else $error("Internal tick missing.");
   a_drive_follow : assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) ##1 o_output_drive_half
      == $past(options_q[BIT_DRIVE_HALF]))
      else $error("Drive setting wrong.");
   a_options_reset : assert property (@(posedge i_ref_clk)
      $rose(i_rst_n) |-> options_q == OPTIONS_RESET)
      else $error("Options not reset.");
   c_link_err : cover property (@(posedge i_ref_clk) $rose(link_err_q));
   c_map_err : cover property (@(posedge i_ref_clk) $rose(map_err_q));
   c_fifo_full : cover property (@(posedge i_ref_clk) !fifo_in_ready);
endmodule

// File: design/cco_pkg.sv
// Package for the converter options block: offsets, fields, resets, types.
package cco_pkg;

   // ------------------------------------------------------------------
   // Register byte addresses (index times four)
   // ------------------------------------------------------------------
   localparam logic [3:0]  IDX_OPTIONS    = 4'h8;
   localparam logic [3:0]  IDX_MAP_CRC    = 4'hF;
   localparam logic [11:0] ADDR_OPTIONS   = 12'h020;
   localparam logic [11:0] ADDR_MAP_CRC   = 12'h03C;
   localparam logic [11:0] ADDR_STATUS    = 12'h040;
   localparam logic [11:0] ADDR_MAP_BASE  = 12'h080;
   localparam logic [11:0] ADDR_MAP_LAST  = 12'h0B0;

   // ------------------------------------------------------------------
   // Options register fields and reset
   // ------------------------------------------------------------------
   localparam int          BIT_CLK_EXT    = 7;
   localparam int          BIT_CLK_DIV8   = 6;
   localparam int          BIT_DRIVE_HALF = 5;
   localparam int          BIT_RESERVED   = 4;
   localparam int          BIT_RES16      = 3;
   localparam int          BIT_LINK_CRC   = 2;
   localparam int          BIT_MAP_CRC    = 1;
   localparam int          BIT_STAT_PRE   = 0;
   localparam logic [7:0]  OPTIONS_RESET  = 8'h00;
   localparam logic [7:0]  OPTIONS_WMASK  = 8'hEF;

   // ------------------------------------------------------------------
   // Status byte fields, CRC and clocking constants
   // ------------------------------------------------------------------
   localparam int          BIT_LINK_ERR   = 1;
   localparam int          BIT_MAP_ERR    = 0;
   localparam logic [7:0]  CRC_POLY       = 8'h07;
   localparam logic [7:0]  CRC_PRESET     = 8'hFF;
   localparam logic [2:0]  EXT_DIV_LAST   = 3'h7;
   localparam int          MAP_REGS       = 13;
   localparam int          FIFO_DEPTH     = 8;

   typedef struct packed
   {
      logic        status_valid;
      logic [7:0]  status;
      logic [23:0] data;
      logic        res16;
      logic [7:0]  crc;
      logic        crc_valid;
   } cco_word_t;

   localparam int WORD_W = $bits(cco_word_t);

   typedef enum logic [1:0]
   {
      MAP_IDLE = 2'b00,
      MAP_WALK = 2'b01,
      MAP_DONE = 2'b10
   } cco_map_state_t;

   // One CRC-8 byte step, MSB first.
   function automatic logic [7:0] crc8_byte(input logic [7:0] crc,
                                            input logic [7:0] b);
      logic [7:0] c;
      c = crc ^ b;
      for (int k = 0; k < 8; k++)
      begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

endpackage

// File: design/cco_fifo.sv
// Output word FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module cco_fifo
   import cco_pkg::*;
#(
   parameter int W     = 8,
   parameter int DEPTH = 8
)
(
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data  = mem[rd_q];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   always_ff @(posedge i_ref_clk)
   begin
      if (push)
      begin
         mem[wr_q] <= i_in_data;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + AW'(1);
         end
         if (pop)
         begin
            rd_q <= rd_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_fifo_no_overfill : assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) cnt_q <= (AW+1)'(DEPTH))
      else $error("FIFO count above depth.");
endmodule

// File: testbench/cco_host_model.sv
// Host-side stream source and sink model for the options block.
`timescale 1ns/1ps
module cco_host_model
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_conv_ready,
   output logic             o_conv_valid,
   output logic [23:0]      o_conv_data,
   input  wire logic        i_out_valid,
   output logic             o_out_ready,
   input  wire logic [42:0] i_out_word
);
   logic [42:0] got_q[$];
   logic        stall;
   logic [1:0]  pace_q;

   initial
   begin
      o_conv_valid = 1'b0;
      o_conv_data  = 24'h000000;
      o_out_ready  = 1'b0;
      stall        = 1'b0;
      pace_q       = 2'h0;
   end

   // Ready is offered one cycle in four, so the output stage must hold.
   always @(posedge i_ref_clk)
   begin
      pace_q      <= pace_q + 2'h1;
      o_out_ready <= !stall && (pace_q == 2'h3);
      if (i_out_valid === 1'b1 && o_out_ready === 1'b1)
         got_q.push_back(i_out_word);
   end

   // A word not taken within six edges counts as refused.
   task automatic push(input logic [23:0] d, output logic ok);
      int n;
      n  = 0;
      ok = 1'b0;
      @(posedge i_ref_clk);
      o_conv_valid <= 1'b1;
      o_conv_data  <= d;
      while (!ok && n < 6)
      begin
         @(posedge i_ref_clk);
         ok = (i_conv_ready === 1'b1);
         n++;
      end
      o_conv_valid <= 1'b0;
      o_conv_data  <= ~d;
   endtask
endmodule

// File: testbench/converter_config_crc_control_test.sv
// Self-checking bench for the converter options block.
`timescale 1ns/1ps
module converter_config_crc_control_test
   import cco_pkg::*;
;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic        ext_clk, fdone, fbad, conv_valid, conv_ready, out_valid;
   logic        out_ready, st_en, crc_en, res16, tick, ext_sel, drv_half;
   logic        link_err, map_err, ok;
   logic [1:0]  ecnt;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] conv_data, out_data;
   logic [7:0]  out_status, out_crc, crc;
   logic [7:0]  m[13];
   logic [42:0] w;
   logic [3:0]  pstrb;
   int          num_errors, comparisons, n, ok_n;

   cco_options u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_ext_clk(ext_clk),
      .i_frame_done(fdone), .i_frame_crc_bad(fbad),
      .i_conv_valid(conv_valid), .i_conv_data(conv_data),
      .o_conv_ready(conv_ready), .o_out_valid(out_valid),
      .i_out_ready(out_ready), .o_out_status(out_status),
      .o_out_status_en(st_en), .o_out_data(out_data),
      .o_out_res16(res16), .o_out_crc(out_crc), .o_out_crc_en(crc_en),
      .o_clk_tick(tick), .o_clk_ext_sel(ext_sel),
      .o_output_drive_half(drv_half), .o_link_err(link_err),
      .o_map_err(map_err));

   cco_host_model u_host (.i_ref_clk(clk), .i_conv_ready(conv_ready),
      .o_conv_valid(conv_valid), .o_conv_data(conv_data),
      .i_out_valid(out_valid), .o_out_ready(out_ready),
      .i_out_word({res16, out_crc, st_en, out_status, out_data, crc_en}));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // External clock at a quarter of the reference rate.
   always @(posedge clk)
   begin
      ecnt    <= ecnt + 2'h1;
      ext_clk <= ecnt[1];
   end

   task automatic final_report;
      $display("Errors %0d, comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      final_report;
   end

   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      comparisons++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clk);
   endtask

   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [7:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
      apb(a, 1'b0, 8'h00);
      chk({1'b0, er, rd}, {2'b00, 24'h000000, e});
   endtask

   task automatic frame(input logic bad);
      @(posedge clk);
      fdone <= 1'b1;
      fbad  <= bad;
      @(posedge clk);
      fdone <= 1'b0;
      fbad  <= 1'b0;
   endtask

   task automatic drain(input int cnt);
      int k;
      k = 0;
      while (u_host.got_q.size() < cnt && k < 300)
      begin
         @(posedge clk);
         k++;
      end
   endtask

   function automatic logic [7:0] crc_ref(input logic [7:0] c,
                                          input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction

   initial
   begin
      num_errors = 0;
      comparisons = 0;
      rst_n = 1'b0;
      {psel, penable, pwrite, fdone, fbad, ext_clk} = 6'h00;
      {paddr, pwdata, ecnt} = 46'h0;
      pstrb = 4'hF;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(ADDR_OPTIONS, 8'h00);
      rdchk(ADDR_STATUS, 8'h00);
      apb(12'h0FC, 1'b0, 8'h00);
      chk({er, rd}, {1'b1, 32'h00000000});
      apb(ADDR_OPTIONS, 1'b1, 8'hFF);
      rdchk(ADDR_OPTIONS, 8'hEF);
      idle(2);
      chk({ext_sel, drv_half}, 2'h3);
      // Tick count over sixteen external edges per clock setting.
      for (int i = 0; i < 3; i++)
      begin
         apb(ADDR_OPTIONS, 1'b1, i == 0 ? 8'h00 : (i == 1 ? 8'h80 : 8'hC0));
         idle(8);
         n = 0;
         repeat (64) @(posedge clk) n += int'(tick === 1'b1);
         chk(34'(n), i == 0 ? 34'd64 : (i == 1 ? 34'd16 : 34'd2));
      end
      // A write without the low byte strobe must leave the options alone.
      pstrb <= 4'hE;
      apb(ADDR_OPTIONS, 1'b1, 8'h04);
      pstrb <= 4'hF;
      rdchk(ADDR_OPTIONS, 8'hC0);
      apb(ADDR_OPTIONS, 1'b1, 8'h04);
      frame(1'b1);
      idle(10);
      chk(link_err, 1'b1);
      rdchk(ADDR_STATUS, 8'h02);
      apb(ADDR_STATUS, 1'b1, 8'h02);
      idle(3);
      chk(link_err, 1'b0);
      frame(1'b0);
      idle(3);
      chk(link_err, 1'b0);
      apb(ADDR_OPTIONS, 1'b1, 8'h00);
      frame(1'b1);
      idle(3);
      chk(link_err, 1'b0);
      apb(ADDR_OPTIONS, 1'b1, 8'h0D);
      u_host.push(24'hA5C37E, ok);
      drain(1);
      w = u_host.got_q[0];
      chk(w[33:0], {1'b1, 8'h00, 24'h00A5C3, 1'b1});
      crc = crc_ref(crc_ref(8'hFF, 8'h00), 8'h00);
      crc = crc_ref(crc_ref(crc, 8'hA5), 8'hC3);
      chk({25'h0, w[42:34]}, {25'h0, 1'b1, crc});
      apb(ADDR_OPTIONS, 1'b1, 8'h00);
      u_host.push(24'h123456, ok);
      drain(2);
      w = u_host.got_q[1];
      chk({w[42], w[33], w[24:0]}, {2'b00, 24'h123456, 1'b0});
      // Fill the FIFO against a stalled sink, then drain it in order.
      u_host.stall = 1'b1;
      ok_n = 0;
      for (int i = 0; i < 12; i++)
      begin
         u_host.push(24'h000100 + 24'(i), ok);
         ok_n += int'(ok);
      end
      chk({conv_ready, 1'(ok_n >= 8 && ok_n < 12)}, 2'b01);
      u_host.stall = 1'b0;
      drain(2 + ok_n);
      for (int i = 0; i < ok_n; i++)
         chk(u_host.got_q[2 + i][24:1], 24'h000100 + 24'(i));
      crc = 8'hFF;
      for (int i = 0; i < 13; i++)
      begin
         m[i] = 8'(17 * (i + 1));
         apb(ADDR_MAP_BASE + 12'(4 * i), 1'b1, m[i]);
         crc = crc_ref(crc, m[i]);
      end
      apb(ADDR_MAP_CRC, 1'b1, crc);
      apb(ADDR_OPTIONS, 1'b1, 8'h02);
      idle(40);
      chk(map_err, 1'b0);
      apb(ADDR_MAP_BASE, 1'b1, ~m[0]);
      idle(40);
      chk(map_err, 1'b1);
      rdchk(ADDR_STATUS, 8'h01);
      apb(ADDR_OPTIONS, 1'b1, 8'h00);
      apb(ADDR_STATUS, 1'b1, 8'h01);
      idle(40);
      chk(map_err, 1'b0);
      final_report;
   end
endmodule
